// ---- shared/sgsc_pkg.sv ----
package sgsc_pkg;
   // chain geometry
   localparam int NPORTS = 32;
   localparam int BPP = 4;
   localparam int SRC_W = 3;
   localparam int PCFG_W = BPP * SRC_W;
   localparam int RATE_W = 16;
   localparam int GAP_W = 6;

   // register byte offsets and decode masks
   localparam logic [11:0] OFS_GEN = 12'h000;
   localparam logic [11:0] OFS_CLK = 12'h004;
   localparam logic [11:0] OFS_PEN = 12'h008;
   localparam logic [11:0] OFS_STAT = 12'h00C;
   localparam logic [11:0] OFS_IN = 12'h010;
   localparam logic [11:0] OFS_STK = 12'h020;
   localparam logic [11:0] OFS_PCFG = 12'h080;
   localparam logic [11:0] GRP4_MASK = 12'hFF0;
   localparam logic [11:0] GRP32_MASK = 12'hF80;
   localparam int WORD_LSB = 2;
   localparam int IDX4_MSB = 3;
   localparam int IDX32_MSB = 6;

   // general_cfg field positions
   localparam int GEN_TRIG = 0;
   localparam int GEN_REP = 1;
   localparam int GEN_WID = 2;
   localparam int GEN_RIN = 4;
   localparam int GEN_ROUT = 5;
   localparam int GEN_LDPOL = 6;
   localparam int GEN_GAPDIS = 7;
   localparam int GEN_GAP = 8;
   localparam int GEN_BM0 = 16;
   localparam int GEN_BM1 = 18;
   // status field positions
   localparam int STAT_ST = 0;
   localparam int STAT_BUSY = 2;
   localparam int STAT_PH = 3;

   // reset values and limits
   localparam logic [RATE_W-1:0] RST_RATE = 16'h0004;
   localparam logic [RATE_W-1:0] HALF_MIN = 16'h0004;
   localparam logic [1:0] RST_WIDTH = 2'h3;
   localparam logic [GAP_W-1:0] GAP_MAX = 6'h21;
   localparam logic [1:0] BLINK_TOGGLE = 2'h3;

   // timing
   localparam int CLK_NS = 10;
   localparam int LOAD_NS = 28;
   localparam int LOAD_CYC = (LOAD_NS + CLK_NS - 1) / CLK_NS;
   localparam int GAP_STEP_NS = 1000000;
   localparam int BLINK_HALF_NS = 25000000;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SHIFT = 2'b01,
      ST_LOAD = 2'b11,
      ST_GAP = 2'b10
   } sgsc_fsm_e;

   typedef enum logic [2:0] {
      SRC_ZERO = 3'h0,
      SRC_ONE = 3'h1,
      SRC_BLINK0 = 3'h2,
      SRC_BLINK1 = 3'h3,
      SRC_ACT0 = 3'h4,
      SRC_ACT1 = 3'h5,
      SRC_NACT0 = 3'h6,
      SRC_NACT1 = 3'h7
   } sgsc_src_e;
endpackage

// ---- rtl/sgsc_serial_io_controller.sv ----
`timescale 1ns/100ps
// What this block does
// (R1) holds 128 serial bits as 32 ports of up to four bits
// (R2) shifts configured bits out on serial data, then asserts load strobe
// (R3) samples serial input in the same bit cycles, readable by software
// (R4) only enabled ports take part; disabled ports skipped in both streams
// (R5) one programmable width of one to four bits for all enabled ports
// (R6) each bit position is output and input at once
// (R7) a burst never exceeds 32 times 4 data clock cycles
// (R8) burst gap programmable in 1 ms steps up to 33 ms, with disable
// (R9) single-shot control launches one burst, cleared by hardware afterwards
// (R10) auto-repeat issues bursts with gaps until software clears it
// (R11) outgoing bits from per-port source config; inputs in readable register
// (R12) load strobe pulses at least 28 ns (LOAD_CYC whole clocks) after each burst, polarity selectable
// (R13) shift clock rate set by a software clock field
// (R14) load only after a burst; shifted inputs come from previous load
// (R15) software issues two bursts to obtain one fresh input sample
// (R16) port order of out and in streams separately reversible
// (R17) external chain length equals enabled ports times bits per port
// (R18) input positions need load-capable shift registers
// (R19) external stages update on load rising edge, shift while load high
// (R20) output source: static, two blink patterns, or link activity
// (R21) sticky per-input flag, cleared by writing one
// (R22) shift clock runs only during a burst, idle level otherwise
// (R23) data out changes while clock low; data in sampled on rising edge
module sgsc_serial_io_controller
   import sgsc_pkg::*;
#(
   parameter int MS_CYCLES = sgsc_pkg::GAP_STEP_NS / sgsc_pkg::CLK_NS,
   parameter int BLINK_CYCLES = sgsc_pkg::BLINK_HALF_NS / sgsc_pkg::CLK_NS
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // per-port activity from the port modules
   input wire logic [sgsc_pkg::NPORTS-1:0] port_activity,
   // shift chain pins
   output logic shift_clock_out,
   output logic load_strobe_out,
   output logic serial_data_out,
   input wire logic serial_data_in
);
   import sgsc_pkg::*;

   typedef struct packed {
      sgsc_fsm_e state;
      logic trig;
      logic rep;
      logic [1:0] width;
      logic rev_in;
      logic rev_out;
      logic ld_pol;
      logic gap_dis;
      logic [GAP_W-1:0] gap_len;
      logic [1:0] bm0;
      logic [1:0] bm1;
      logic [RATE_W-1:0] rate;
      logic [NPORTS-1:0] pen;
      logic [NPORTS-1:0][PCFG_W-1:0] pcfg; // [R1]
      logic [BPP-1:0][NPORTS-1:0] in_data;
      logic [BPP-1:0][NPORTS-1:0] stk;
      logic [5:0] op;
      logic [5:0] ip;
      logic [1:0] bitn;
      logic [RATE_W-1:0] half;
      logic phase;
      logic [1:0] ld_cnt;
      logic [GAP_W-1:0] gap_cnt;
      logic [31:0] ms_cnt;
      logic [31:0] blink_cnt;
      logic [3:0] blink_div;
      logic burst_tog;
      logic din_s1;
      logic din_s2;
      logic sclk;
      logic sdo;
      logic sld;
      logic a_wr;
      logic a_rd;
      logic [11:0] a_addr;
      logic hready_o;
      logic [31:0] rdata;
   } sgsc_regs_s;

   sgsc_regs_s r_r;
   sgsc_regs_s r_nxt;

   // next-state logic: bus slave, register file, burst engine, blink
   always_comb begin
      logic [31:0] rd;
      logic wr_gen;
      logic [4:0] oport;
      logic [4:0] iport;
      logic out_en;
      logic in_en;
      logic [RATE_W-1:0] half_lim;
      logic [GAP_W-1:0] gap_lim;
      logic blink0;
      logic blink1;
      logic act;
      logic obit;
      logic start;
      sgsc_src_e src;
      rd = '0;
      wr_gen = 1'b0;
      start = 1'b0;
      oport = '0;
      iport = '0;
      out_en = 1'b0;
      in_en = 1'b0;
      half_lim = HALF_MIN;
      gap_lim = '0;
      blink0 = 1'b0;
      blink1 = 1'b0;
      act = 1'b0;
      obit = 1'b0;
      src = SRC_ZERO;
      r_nxt = r_r;

      // address phase; reads take one wait state so a write just
      // before them is already visible
      r_nxt.a_wr = 1'b0;
      r_nxt.a_rd = 1'b0;
      r_nxt.hready_o = 1'b1;
      if (hsel && htrans[1] && hready) begin
         r_nxt.a_wr = hwrite;
         r_nxt.a_rd = !hwrite;
         r_nxt.a_addr = haddr[11:0];
         r_nxt.hready_o = hwrite;
      end

      // read mux, unmapped words read as zero
      if (r_r.a_addr == OFS_GEN) begin
         rd[GEN_TRIG] = r_r.trig;
         rd[GEN_REP] = r_r.rep;
         rd[GEN_WID +: 2] = r_r.width;
         rd[GEN_RIN] = r_r.rev_in;
         rd[GEN_ROUT] = r_r.rev_out;
         rd[GEN_LDPOL] = r_r.ld_pol;
         rd[GEN_GAPDIS] = r_r.gap_dis;
         rd[GEN_GAP +: GAP_W] = r_r.gap_len;
         rd[GEN_BM0 +: 2] = r_r.bm0;
         rd[GEN_BM1 +: 2] = r_r.bm1;
      end else if (r_r.a_addr == OFS_CLK) begin
         rd[RATE_W-1:0] = r_r.rate;
      end else if (r_r.a_addr == OFS_PEN) begin
         rd = r_r.pen;
      end else if (r_r.a_addr == OFS_STAT) begin
         rd[STAT_ST +: 2] = r_r.state;
         rd[STAT_BUSY] = (r_r.state != ST_IDLE);
         rd[STAT_PH] = r_r.phase;
      end else if ((r_r.a_addr & GRP4_MASK) == OFS_IN) begin
         rd = r_r.in_data[r_r.a_addr[IDX4_MSB:WORD_LSB]]; // [R3] [R11]
      end else if ((r_r.a_addr & GRP4_MASK) == OFS_STK) begin
         rd = r_r.stk[r_r.a_addr[IDX4_MSB:WORD_LSB]];
      end else if ((r_r.a_addr & GRP32_MASK) == OFS_PCFG) begin
         rd[PCFG_W-1:0] = r_r.pcfg[r_r.a_addr[IDX32_MSB:WORD_LSB]];
      end
      if (r_r.a_rd) begin
         r_nxt.rdata = rd;
      end

      // data phase writes
      if (r_r.a_wr) begin
         if (r_r.a_addr == OFS_GEN) begin
            wr_gen = 1'b1;
            r_nxt.trig = hwdata[GEN_TRIG];
            r_nxt.rep = hwdata[GEN_REP];
            r_nxt.width = hwdata[GEN_WID +: 2]; // [R5]
            r_nxt.rev_in = hwdata[GEN_RIN];
            r_nxt.rev_out = hwdata[GEN_ROUT];
            r_nxt.ld_pol = hwdata[GEN_LDPOL];
            r_nxt.gap_dis = hwdata[GEN_GAPDIS];
            r_nxt.gap_len = hwdata[GEN_GAP +: GAP_W];
            r_nxt.bm0 = hwdata[GEN_BM0 +: 2];
            r_nxt.bm1 = hwdata[GEN_BM1 +: 2];
         end else if (r_r.a_addr == OFS_CLK) begin
            r_nxt.rate = hwdata[RATE_W-1:0]; // [R13]
         end else if (r_r.a_addr == OFS_PEN) begin
            r_nxt.pen = hwdata;
         end else if ((r_r.a_addr & GRP4_MASK) == OFS_STK) begin
            // write one to clear; captures below win the same cycle
            r_nxt.stk[r_r.a_addr[IDX4_MSB:WORD_LSB]] =
               r_r.stk[r_r.a_addr[IDX4_MSB:WORD_LSB]] & ~hwdata; // [R21]
         end else if ((r_r.a_addr & GRP32_MASK) == OFS_PCFG) begin
            r_nxt.pcfg[r_r.a_addr[IDX32_MSB:WORD_LSB]] =
               hwdata[PCFG_W-1:0]; // [R20]
         end
      end

      // blink base: divider bit k toggles at 20 Hz / 2^k
      if (r_r.blink_cnt == 32'(BLINK_CYCLES - 1)) begin
         r_nxt.blink_cnt = '0;
         r_nxt.blink_div = r_r.blink_div + 4'h1;
      end else begin
         r_nxt.blink_cnt = r_r.blink_cnt + 32'h1;
      end
      blink0 = r_r.blink_div[r_r.bm0];
      blink1 = (r_r.bm1 == BLINK_TOGGLE) ? r_r.burst_tog :
               r_r.blink_div[r_r.bm1];

      // port cursors; reversal mirrors the port number
      oport = r_r.rev_out ? ~r_r.op[4:0] : r_r.op[4:0]; // [R16]
      iport = r_r.rev_in ? ~r_r.ip[4:0] : r_r.ip[4:0]; // [R16]
      out_en = r_r.pen[oport];
      in_en = r_r.ip[5] | r_r.pen[iport];
      act = port_activity[oport];
      src = sgsc_src_e'(r_r.pcfg[oport][SRC_W*r_r.bitn +: SRC_W]);
      case (src) // [R20]
         SRC_ZERO: obit = 1'b0;
         SRC_ONE: obit = 1'b1;
         SRC_BLINK0: obit = blink0;
         SRC_BLINK1: obit = blink1;
         SRC_ACT0: obit = act & blink0;
         SRC_ACT1: obit = act & blink1;
         SRC_NACT0: obit = ~(act & blink0);
         SRC_NACT1: obit = ~(act & blink1);
         default: obit = 1'b0;
      endcase
      half_lim = (r_r.rate < HALF_MIN) ? HALF_MIN : r_r.rate; // [R13]
      gap_lim = (r_r.gap_len > GAP_MAX) ? GAP_MAX : r_r.gap_len; // [R8]

      // two-flop sync of the serial input
      r_nxt.din_s1 = serial_data_in;
      r_nxt.din_s2 = r_r.din_s1;

      // burst engine
      case (r_r.state)
         ST_IDLE: begin
            start = r_r.trig | r_r.rep; // [R9] [R10]
         end
         ST_SHIFT: begin
            if (r_r.op[5]) begin
               // all 32 ports walked: load strobe after the burst only
               r_nxt.state = ST_LOAD; // [R2] [R7] [R14]
               r_nxt.ld_cnt = '0;
            end else if (!out_en || !in_en) begin
               // skipping costs a cycle but no clock pulse
               if (!out_en) begin
                  r_nxt.op = r_r.op + 6'h1; // [R4]
               end
               if (!in_en) begin
                  r_nxt.ip = r_r.ip + 6'h1; // [R4]
               end
               r_nxt.bitn = '0;
            end else begin
               if (!r_r.phase && r_r.half == '0) begin
                  r_nxt.sdo = obit; // [R2] [R6] [R11] [R23]
               end
               if (r_r.half == half_lim - 16'h1) begin
                  r_nxt.half = '0;
                  r_nxt.phase = ~r_r.phase;
                  r_nxt.sclk = ~r_r.phase; // [R22]
                  if (!r_r.phase) begin
                     // rising edge: the chain shifts on it, so sample first
                     r_nxt.in_data[r_r.bitn][iport] = r_r.din_s2; // [R3] [R23]
                     if (r_r.din_s2) begin
                        r_nxt.stk[r_r.bitn][iport] = 1'b1; // [R21]
                     end
                  end else if (r_r.bitn == r_r.width) begin
                     r_nxt.bitn = '0; // [R5]
                     r_nxt.op = r_r.op + 6'h1;
                     r_nxt.ip = r_r.ip + 6'h1;
                  end else begin
                     r_nxt.bitn = r_r.bitn + 2'h1;
                  end
               end else begin
                  r_nxt.half = r_r.half + 16'h1;
               end
            end
         end
         ST_LOAD: begin
            if (r_r.ld_cnt == 2'(LOAD_CYC - 1)) begin // [R12]
               r_nxt.burst_tog = ~r_r.burst_tog;
               if (!wr_gen) begin
                  r_nxt.trig = 1'b0; // [R9]
               end
               if (r_r.rep && !r_r.gap_dis && gap_lim != '0) begin
                  r_nxt.state = ST_GAP; // [R8] [R10]
                  r_nxt.gap_cnt = '0;
                  r_nxt.ms_cnt = '0;
               end else if (r_r.rep) begin
                  start = 1'b1; // [R10]
               end else begin
                  r_nxt.state = ST_IDLE;
               end
            end else begin
               r_nxt.ld_cnt = r_r.ld_cnt + 2'h1;
            end
         end
         ST_GAP: begin
            if (!r_r.rep) begin
               r_nxt.state = ST_IDLE; // [R10]
            end else if (r_r.gap_cnt == gap_lim) begin
               start = 1'b1; // [R8]
            end else if (r_r.ms_cnt == 32'(MS_CYCLES - 1)) begin
               r_nxt.ms_cnt = '0;
               r_nxt.gap_cnt = r_r.gap_cnt + 6'h1; // [R8]
            end else begin
               r_nxt.ms_cnt = r_r.ms_cnt + 32'h1;
            end
         end
         default: begin
            r_nxt.state = ST_IDLE;
         end
      endcase
      if (start) begin
         r_nxt.state = ST_SHIFT;
         r_nxt.op = '0;
         r_nxt.ip = '0;
         r_nxt.bitn = '0;
         r_nxt.half = '0;
         r_nxt.phase = 1'b0;
         r_nxt.sclk = 1'b0;
      end
      // strobe rises at burst end for active-high, so external
      // stages latch on the rising edge
      r_nxt.sld = (r_nxt.state == ST_LOAD) ? ~r_r.ld_pol :
                  r_r.ld_pol; // [R12] [R19]
   end

   // single state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_r <= '0;
         r_r.width <= RST_WIDTH;
         r_r.rate <= RST_RATE;
         r_r.hready_o <= 1'b1;
      end else begin
         r_r <= r_nxt;
      end
   end

   // outputs straight from flops, hresp tied low
   assign hreadyout = r_r.hready_o;
   assign hrdata = r_r.rdata;
   assign hresp = 1'b0;
   assign shift_clock_out = r_r.sclk;
   assign load_strobe_out = r_r.sld;
   assign serial_data_out = r_r.sdo;
endmodule

// ---- tb/sgsc_sio_assertions.sv ----
`timescale 1ns/100ps
module sgsc_sio_assertions
   import sgsc_pkg::*;
#(
   parameter int MS_CYCLES = 20,
   parameter int BLINK_CYCLES = 8
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // activity and chain pins
   input wire logic [NPORTS-1:0] port_activity,
   input wire logic shift_clock_out,
   input wire logic load_strobe_out,
   input wire logic serial_data_out,
   input wire logic serial_data_in
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic taken;
   logic clk_q_r;
   logic ld_q_r;
   logic [7:0] rise_cnt_r;
   assign taken = hsel & htrans[1] & hready;
   // rises between strobe edges; saturates so a runaway still fails
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_q_r <= 1'b0;
         ld_q_r <= 1'b0;
         rise_cnt_r <= 8'h00;
      end else begin
         clk_q_r <= shift_clock_out;
         ld_q_r <= load_strobe_out;
         if (ld_q_r != load_strobe_out) rise_cnt_r <= 8'h00;
         else if (shift_clock_out && !clk_q_r && rise_cnt_r != 8'hFF)
            rise_cnt_r <= rise_cnt_r + 8'h01;
      end
   end
   a_okay_resp: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   a_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_write_nowait: assert property (taken && hwrite |=> hreadyout)
      else $error("write stalled");
   a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
      else $error("read data moved outside a read");
   a_clk_high_min: assert property (
      $rose(shift_clock_out) |=> shift_clock_out [*3])
      else $error("shift clock high half too short");
   a_clk_low_min: assert property (
      $fell(shift_clock_out) |=> !shift_clock_out [*3])
      else $error("shift clock low half too short");
   a_sdo_steady: assert property (
      shift_clock_out |-> $stable(serial_data_out))
      else $error("serial data moved while clock high");
   a_ld_clk_idle: assert property (
      $changed(load_strobe_out) |-> !shift_clock_out [*3])
      else $error("shift clock ran around the strobe");
   a_ld_width: assert property (
      $changed(load_strobe_out) |=> $stable(load_strobe_out) [*2])
      else $error("load strobe pulse too short");
   a_burst_max: assert property (rise_cnt_r <= 8'd128)
      else $error("burst longer than full chain");
endmodule
bind sgsc_serial_io_controller sgsc_sio_assertions #(
   .MS_CYCLES(MS_CYCLES),
   .BLINK_CYCLES(BLINK_CYCLES)
) u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .port_activity(port_activity),
   .shift_clock_out(shift_clock_out), .load_strobe_out(load_strobe_out),
   .serial_data_out(serial_data_out), .serial_data_in(serial_data_in)
);

// ---- tb/sgsc_chain_model.sv ----
`timescale 1ns/100ps
module sgsc_chain_model #(
   parameter int LEN = 4
) (
   // chain pins
   input wire logic shift_clock_out,
   input wire logic load_strobe_out,
   input wire logic serial_data_out,
   output logic serial_data_in,
   // board side
   input wire logic ld_pol,
   input wire logic ser_fill,
   input wire logic [LEN-1:0] par_in,
   output logic [LEN-1:0] par_out,
   output int n_load
);
   logic [LEN-1:0] out_sr = '0;
   logic [LEN-1:0] in_sr = '0;
   initial par_out = '0;
   initial n_load = 0;
   // both chains move on the rising shift clock edge
   always @(posedge shift_clock_out) begin
      out_sr <= {out_sr[LEN-2:0], serial_data_out};
      in_sr <= {in_sr[LEN-2:0], ser_fill};
   end
   // one strobe edge updates outputs and loads inputs
   always @(load_strobe_out) begin
      if (load_strobe_out !== ld_pol) begin
         par_out <= out_sr;
         in_sr <= par_in;
         n_load <= n_load + 1;
      end
   end
   assign serial_data_in = in_sr[LEN-1];
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
   import sgsc_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [NPORTS-1:0] port_activity;
   logic sck, ld, sdo, sdi;
   logic ld_pol = 1'b0;
   logic ser_fill = 1'b0;
   logic [3:0] par_in = 4'h0;
   logic [3:0] par_out;
   int n_load;
   int failures = 0;
   int n_tests = 0;
   int n_rise = 0;
   int hi_cnt = 0;
   int hi_len = 0;
   assign hready = hreadyout;
   always #5 hclk = ~hclk;
   sgsc_serial_io_controller #(.MS_CYCLES(20), .BLINK_CYCLES(8)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .port_activity(port_activity),
      .shift_clock_out(sck), .load_strobe_out(ld),
      .serial_data_out(sdo), .serial_data_in(sdi));
   sgsc_chain_model #(.LEN(4)) u_chain (
      .shift_clock_out(sck), .load_strobe_out(ld), .serial_data_out(sdo),
      .serial_data_in(sdi), .ld_pol(ld_pol), .ser_fill(ser_fill),
      .par_in(par_in), .par_out(par_out), .n_load(n_load));
   // rises and high-half length of the shift clock
   always @(posedge hclk) begin
      if (sck === 1'b1) begin
         if (hi_cnt == 0) n_rise = n_rise + 1;
         hi_cnt = hi_cnt + 1;
      end else if (hi_cnt != 0) begin
         hi_len = hi_cnt;
         hi_cnt = 0;
      end
   end
   task check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task give_verdict;
      if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // one single transfer; address held until hready, then data phase
   task ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task rd_chk(input logic [31:0] a, input logic [31:0] exp);
      ahb_xfer(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   // launch one burst and wait for the trigger to drop
   task burst(input logic [31:0] g);
      ahb_xfer(1'b1, 32'(OFS_GEN), g | 32'h1);
      for (int i = 0; i < 500; i++) begin
         ahb_xfer(1'b0, 32'(OFS_GEN), 32'h0);
         if (rd[GEN_TRIG] === 1'b0) break;
      end
      check(rd[GEN_TRIG], 1'b0);
      repeat (10) @(posedge hclk);
   endtask
   task t_reset;
      rd_chk(32'(OFS_GEN), {30'h0, RST_WIDTH} << GEN_WID);
      rd_chk(32'(OFS_CLK), {16'h0, RST_RATE});
      rd_chk(32'(OFS_PEN), 32'h0);
      ahb_xfer(1'b1, 32'h40, 32'hFFFFFFFF);
      rd_chk(32'h40, 32'h0);
   endtask
   // ports 0 and 2 of two bits each, port 1 skipped
   task t_out(input logic rev);
      ahb_xfer(1'b1, 32'(OFS_CLK), 32'h6);
      ahb_xfer(1'b1, 32'(OFS_PEN), 32'h5);
      ahb_xfer(1'b1, 32'(OFS_PCFG), 32'h001);
      ahb_xfer(1'b1, 32'(OFS_PCFG) + 4, 32'h001);
      ahb_xfer(1'b1, 32'(OFS_PCFG) + 8, 32'h031);
      n_rise = 0;
      burst((32'h1 << GEN_WID) | (32'(rev) << GEN_ROUT));
      check(n_rise, 4);
      check(hi_len, 6);
      check(par_out, rev ? 4'hE : 4'hB);
   endtask
   // port 5 at four bits, chain inputs all high
   task t_in;
      ahb_xfer(1'b1, 32'(OFS_PEN), 32'h20);
      ahb_xfer(1'b1, 32'(OFS_PCFG) + 20, 32'h249);
      par_in <= 4'hF;
      burst(32'h3 << GEN_WID);
      rd_chk(32'(OFS_IN), 32'h0);
      ser_fill <= 1'b0; // zero fill exposes a late last sample
      burst(32'h3 << GEN_WID);
      check(par_out, 4'hF);
      for (int k = 0; k < 4; k++) rd_chk(32'(OFS_IN) + 4 * k, 32'h20);
      ahb_xfer(1'b1, 32'(OFS_STK), 32'h20);
      rd_chk(32'(OFS_STK), 32'h0);
      rd_chk(32'(OFS_STK) + 4, 32'h20);
   endtask
   // repeated bursts, active-low strobe, gap then no gap, then stop
   task t_rep;
      int a, b, c;
      logic [31:0] g;
      g = 32'h2 | (32'h1 << GEN_LDPOL) | (32'h3 << GEN_WID) | (32'h8 << GEN_GAP);
      ld_pol <= 1'b1;
      ahb_xfer(1'b1, 32'(OFS_GEN), g);
      a = n_load;
      repeat (600) @(posedge hclk);
      a = n_load - a;
      ahb_xfer(1'b1, 32'(OFS_GEN), g | (32'h1 << GEN_GAPDIS));
      repeat (200) @(posedge hclk); // a gap already running still ends
      b = n_load;
      repeat (600) @(posedge hclk);
      b = n_load - b;
      check(a >= 2 && a <= 3, 1'b1);
      check(b > a + 2, 1'b1);
      ahb_xfer(1'b1, 32'(OFS_GEN), g & ~32'h2);
      repeat (300) @(posedge hclk);
      c = n_load;
      repeat (300) @(posedge hclk);
      check(n_load, c);
      check(ld, 1'b1);
   endtask
   // hang guard
   initial begin
      repeat (60000) @(posedge hclk);
      failures++;
      give_verdict;
   end
   initial begin
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      port_activity = '0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_out(1'b0);
      t_out(1'b1);
      t_in;
      t_rep;
      give_verdict;
   end
endmodule
